/* File: src/vpsr_regs.sv */
// Emulated PHY status and identifier registers with internal and management access.
//
// What this block does
// - Ability bits 14 to 11 read one.
// - Bits 15, 10, 9 always read zero.
// - Bit 8 reads zero, no extended status.
// - Bit 6 reads zero, preamble required.
// - Bit 5 clears on reset, sets later.
// - Fault zero, link one, jabber zero.
// - Bit 3 reads one, negotiation capable.
// - Bit 0 reads one, extended capability.
// - 32-bit words, upper half reads zero.
// - Status at 1C4h and index 1.
// - High identifier at 1C8h, index 2, writable.
// - Low identifier fields writable, default zero.
// - Low identifier at 1CCh and index 3.
// - Soft reset returns registers to defaults.
`timescale 1ns/1ps
`default_nettype none

`include "vpsr_params.svh"

module vpsr_regs #(
  parameter int unsigned AN_SETTLE_CYC = `VPSR_AN_SETTLE_CYC,
  parameter int unsigned AN_CNT_W = 8
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Soft reset pulse from the emulated control register.
  input wire logic emulated_phy_soft_reset_i,
  // Internal 32-bit register port.
  input wire vpsr_pkg::vpsr_int_req_t int_req_i,
  output logic [31:0] int_rdata_o,
  output logic int_rvalid_o,
  // Management 16-bit register port.
  input wire vpsr_pkg::vpsr_mii_req_t mii_req_i,
  output logic [15:0] mii_rdata_o,
  output logic mii_rvalid_o,
  // Negotiation complete level.
  output logic an_complete_o
);

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [15:0] ident_high_reg; // Upper identifier word.
  logic [15:0] ident_high_next; // Next upper identifier word.
  vpsr_pkg::vpsr_ident_low_t ident_low_reg; // Lower identifier fields.
  vpsr_pkg::vpsr_ident_low_t ident_low_next; // Next lower identifier.
  logic [31:0] int_rdata_reg; // Internal read data.
  logic [31:0] int_rdata_next; // Next internal read data.
  logic int_rvalid_reg; // Internal read answer pulse.
  logic int_rvalid_next; // Next internal answer pulse.
  logic [15:0] mii_rdata_reg; // Management read data.
  logic [15:0] mii_rdata_next; // Next management read data.
  logic mii_rvalid_reg; // Management read answer pulse.
  logic mii_rvalid_next; // Next management answer pulse.
  logic an_done_reg; // Copy of the timer flag for the output.
  logic an_done; // Timer flag.
  logic an_restart; // Restart for the emulated negotiation.
  logic [15:0] status_word; // Live status word.
  vpsr_pkg::vpsr_sel_t int_sel; // Register chosen by the internal port.
  vpsr_pkg::vpsr_sel_t mii_sel; // Register chosen by the management port.

  // ****************************************************************
  // Emulated negotiation.
  // ****************************************************************

  assign an_restart = emulated_phy_soft_reset_i;

  // Runs the settle time after reset and after every soft reset.
  vpsr_an_timer #(
    .SETTLE_CYC(AN_SETTLE_CYC),
    .CNT_W(AN_CNT_W)
  ) u_an_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .restart_i(an_restart),
    .done_o(an_done)
  );

  // ****************************************************************
  // Status word.
  // ****************************************************************

  // Builds the status word from its fixed bits and the negotiation flag.
  always_comb begin
    status_word = `VPSR_STATUS_FIXED;
    status_word[`VPSR_STATUS_AN_DONE_BIT] = an_done;
  end

  // ****************************************************************
  // Address decode.
  // ****************************************************************

  always_comb begin
    case (int_req_i.addr)
      `VPSR_STATUS_OFS: int_sel = vpsr_pkg::VPSR_SEL_STATUS;
      `VPSR_IDENT_HIGH_OFS: int_sel = vpsr_pkg::VPSR_SEL_IDENT_HIGH;
      `VPSR_IDENT_LOW_OFS: int_sel = vpsr_pkg::VPSR_SEL_IDENT_LOW;
      default: int_sel = vpsr_pkg::VPSR_SEL_NONE;
    endcase
    case (mii_req_i.idx)
      `VPSR_STATUS_IDX: mii_sel = vpsr_pkg::VPSR_SEL_STATUS;
      `VPSR_IDENT_HIGH_IDX: mii_sel = vpsr_pkg::VPSR_SEL_IDENT_HIGH;
      `VPSR_IDENT_LOW_IDX: mii_sel = vpsr_pkg::VPSR_SEL_IDENT_LOW;
      default: mii_sel = vpsr_pkg::VPSR_SEL_NONE;
    endcase
  end

  // Returns the 16-bit value of a selected register, zero when unmapped.
  function automatic logic [15:0] read_word(input vpsr_pkg::vpsr_sel_t sel,
                                            input logic [15:0] status,
                                            input logic [15:0] high,
                                            input logic [15:0] low);
    logic [15:0] word;
    word = `VPSR_PAD_ZERO;
    case (sel)
      vpsr_pkg::VPSR_SEL_STATUS: word = status;
      vpsr_pkg::VPSR_SEL_IDENT_HIGH: word = high;
      vpsr_pkg::VPSR_SEL_IDENT_LOW: word = low;
      default: word = `VPSR_PAD_ZERO;
    endcase
    return word;
  endfunction

  // ****************************************************************
  // Identifier registers.
  // ****************************************************************

  // Applies writes; the internal port wins over the management port.
  always_comb begin
    ident_high_next = ident_high_reg;
    ident_low_next = ident_low_reg;
    if (emulated_phy_soft_reset_i) begin
      ident_high_next = `VPSR_IDENT_HIGH_RST;
      ident_low_next = `VPSR_IDENT_LOW_RST;
    end else begin
      // Management writes carry only the low 16 bits.
      if (mii_req_i.wr && mii_sel == vpsr_pkg::VPSR_SEL_IDENT_HIGH) begin
        ident_high_next = mii_req_i.wdata;
      end
      if (mii_req_i.wr && mii_sel == vpsr_pkg::VPSR_SEL_IDENT_LOW) begin
        ident_low_next = mii_req_i.wdata;
      end
      if (int_req_i.wr && int_sel == vpsr_pkg::VPSR_SEL_IDENT_HIGH) begin
        ident_high_next = int_req_i.wdata[15:0];
      end
      if (int_req_i.wr && int_sel == vpsr_pkg::VPSR_SEL_IDENT_LOW) begin
        ident_low_next = int_req_i.wdata[15:0];
      end
    end
  end

  // Registers the identifier words.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ident_high_reg <= `VPSR_IDENT_HIGH_RST;
      ident_low_reg <= `VPSR_IDENT_LOW_RST;
    end else begin
      ident_high_reg <= ident_high_next;
      ident_low_reg <= ident_low_next;
    end
  end

  // ****************************************************************
  // Read answers.
  // ****************************************************************

  // Captures read data one cycle after each read strobe.
  always_comb begin
    int_rvalid_next = int_req_i.rd;
    mii_rvalid_next = mii_req_i.rd;
    int_rdata_next = int_rdata_reg;
    mii_rdata_next = mii_rdata_reg;
    if (int_req_i.rd) begin
      int_rdata_next = {`VPSR_PAD_ZERO,
                        read_word(int_sel, status_word, ident_high_reg,
                                  ident_low_reg)};
    end
    if (mii_req_i.rd) begin
      mii_rdata_next = read_word(mii_sel, status_word, ident_high_reg,
                                 ident_low_reg);
    end
  end

  // Registers the read answers and the negotiation flag.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      int_rdata_reg <= 32'h0000_0000;
      int_rvalid_reg <= 1'b0;
      mii_rdata_reg <= 16'h0000;
      mii_rvalid_reg <= 1'b0;
      an_done_reg <= 1'b0;
    end else begin
      int_rdata_reg <= int_rdata_next;
      int_rvalid_reg <= int_rvalid_next;
      mii_rdata_reg <= mii_rdata_next;
      mii_rvalid_reg <= mii_rvalid_next;
      an_done_reg <= an_done;
    end
  end

  assign int_rdata_o = int_rdata_reg;
  assign int_rvalid_o = int_rvalid_reg;
  assign mii_rdata_o = mii_rdata_reg;
  assign mii_rvalid_o = mii_rvalid_reg;
  assign an_complete_o = an_done_reg;

endmodule

`default_nettype wire

/* File: src/vpsr_params.svh */
// Offsets, field positions, reset values and timing counts for the emulated PHY status and identifier registers.
`ifndef VPSR_PARAMS_SVH
`define VPSR_PARAMS_SVH

// ****************************************************************
// Internal register map, byte offsets.
// ****************************************************************
`define VPSR_ADDR_W 9
`define VPSR_STATUS_OFS 9'h1c4
`define VPSR_IDENT_HIGH_OFS 9'h1c8
`define VPSR_IDENT_LOW_OFS 9'h1cc

// ****************************************************************
// Management register indices.
// ****************************************************************
`define VPSR_IDX_W 5
`define VPSR_STATUS_IDX 5'h01
`define VPSR_IDENT_HIGH_IDX 5'h02
`define VPSR_IDENT_LOW_IDX 5'h03

// ****************************************************************
// Status word fixed bits and field positions.
// ****************************************************************
`define VPSR_STATUS_FIXED 16'h780d
`define VPSR_STATUS_AN_DONE_BIT 5
`define VPSR_PAD_ZERO 16'h0000

// ****************************************************************
// Identifier reset values.
// ****************************************************************
`define VPSR_IDENT_HIGH_RST 16'h0000
`define VPSR_IDENT_LOW_RST 16'h0000

// ****************************************************************
// Timing: emulated negotiation settle time.
// ****************************************************************
`define VPSR_CLK_PERIOD_NS 100
`define VPSR_AN_SETTLE_NS 1000
`define VPSR_AN_SETTLE_CYC \
  ((`VPSR_AN_SETTLE_NS + `VPSR_CLK_PERIOD_NS - 1) / `VPSR_CLK_PERIOD_NS)

`endif

/* File: src/vpsr_pkg.sv */
// Types shared by the emulated PHY status and identifier registers.
package vpsr_pkg;

  // Internal 32-bit register access request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [31:0] wdata;
  } vpsr_int_req_t;

  // Management 16-bit register access request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] idx;
    logic [15:0] wdata;
  } vpsr_mii_req_t;

  // Lower identifier word layout.
  typedef struct packed {
    logic [5:0] oui_low;
    logic [5:0] model;
    logic [3:0] revision;
  } vpsr_ident_low_t;

  // Register selector after decode.
  typedef enum logic [1:0] {
    VPSR_SEL_NONE,
    VPSR_SEL_STATUS,
    VPSR_SEL_IDENT_HIGH,
    VPSR_SEL_IDENT_LOW
  } vpsr_sel_t;

endpackage

/* File: src/vpsr_an_timer.sv */
// Emulated negotiation timer that raises a done flag after a settle time.
`timescale 1ns/1ps
`default_nettype none

module vpsr_an_timer #(
  parameter int unsigned SETTLE_CYC = 10,
  parameter int unsigned CNT_W = 8
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Restart request from the soft reset.
  input wire logic restart_i,
  // Negotiation finished.
  output logic done_o
);

  typedef enum logic {
    VPSR_AN_RUN,
    VPSR_AN_DONE
  } vpsr_an_state_t;

  vpsr_an_state_t state_reg; // Current phase of the emulated run.
  vpsr_an_state_t state_next; // Next phase.
  logic [CNT_W-1:0] cnt_reg; // Cycles spent in the run phase.
  logic [CNT_W-1:0] cnt_next; // Next cycle count.
  logic done_reg; // Registered done flag.
  logic done_next; // Next done flag.

  localparam logic [CNT_W-1:0] LAST = CNT_W'(SETTLE_CYC - 1);

  // Counts the settle time, then holds done until the next restart.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    done_next = done_reg;
    if (restart_i) begin
      // A restart clears done at once and starts a fresh run.
      state_next = VPSR_AN_RUN;
      cnt_next = '0;
      done_next = 1'b0;
    end else begin
      case (state_reg)
        VPSR_AN_RUN: begin
          if (cnt_reg == LAST) begin
            state_next = VPSR_AN_DONE;
            done_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + CNT_W'(1);
          end
        end
        VPSR_AN_DONE: begin
          done_next = 1'b1;
        end
        default: begin
          state_next = VPSR_AN_RUN;
          cnt_next = '0;
          done_next = 1'b0;
        end
      endcase
    end
  end

  // Registers the timer state.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg <= VPSR_AN_RUN;
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done_o = done_reg;

endmodule

`default_nettype wire

/* File: bench/vpsr_regs_checker.sv */
// Port checker for the emulated PHY status and identifier registers.
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Checker module and its bind.
// ****************************************************************
module vpsr_regs_checker #(
  parameter int unsigned AN_SETTLE_CYC = 10
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic emulated_phy_soft_reset_i,
  // Internal port.
  input wire vpsr_pkg::vpsr_int_req_t int_req_i,
  input wire logic [31:0] int_rdata_o,
  input wire logic int_rvalid_o,
  // Management port.
  input wire vpsr_pkg::vpsr_mii_req_t mii_req_i,
  input wire logic [15:0] mii_rdata_o,
  input wire logic mii_rvalid_o,
  input wire logic an_complete_o
);
  // Latest cycle by which negotiation must have finished.
  localparam int AN_MAX = AN_SETTLE_CYC + 4;
  // Last cycle after release at which the done flag must still be low.
  localparam int AN_LOW_END = AN_SETTLE_CYC;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  chk_int_read_answer: assert property (
    int_req_i.rd |=> int_rvalid_o) else $error("internal read unanswered");
  chk_int_answer_cause: assert property (
    int_rvalid_o |-> $past(int_req_i.rd)) else $error("stray answer");
  chk_mii_read_answer: assert property (
    mii_req_i.rd |=> mii_rvalid_o) else $error("management read unanswered");
  chk_upper_pad_zero: assert property (
    int_rvalid_o |-> int_rdata_o[31:16] == 16'h0000)
    else $error("padding bits not zero");
  chk_int_status_fixed: assert property (
    int_req_i.rd && int_req_i.addr == 9'h1c4 |=>
    (int_rdata_o & 32'hffffffdf) == 32'h0000780d)
    else $error("internal status fixed bits wrong");
  chk_mii_status_fixed: assert property (
    mii_req_i.rd && mii_req_i.idx == 5'h01 |=>
    (mii_rdata_o & 16'hffdf) == 16'h780d)
    else $error("management status fixed bits wrong");
  chk_an_bit_level: assert property (
    int_req_i.rd && int_req_i.addr == 9'h1c4 |=>
    int_rdata_o[5] == an_complete_o) else $error("done bit and level differ");
  chk_an_after_reset: assert property (
    $fell(rst_i) |-> !an_complete_o [*2] ##[1:AN_MAX] an_complete_o)
    else $error("negotiation done flag timing wrong");
  chk_an_low_settle: assert property (
    $fell(rst_i) |-> ##AN_LOW_END !an_complete_o)
    else $error("negotiation done flag set too early");
  chk_an_soft_clear: assert property (
    emulated_phy_soft_reset_i |-> ##2 !an_complete_o)
    else $error("soft reset left done flag set");
  // Main scenarios that the bench must reach.
  cover property (int_req_i.wr && int_req_i.addr == 9'h1c8);
  cover property (mii_req_i.wr && mii_req_i.idx == 5'h03);
  cover property (emulated_phy_soft_reset_i);
endmodule

bind vpsr_regs vpsr_regs_checker #(.AN_SETTLE_CYC(AN_SETTLE_CYC))
  u_vpsr_regs_checker (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .emulated_phy_soft_reset_i(emulated_phy_soft_reset_i),
  .int_req_i(int_req_i), .int_rdata_o(int_rdata_o),
  .int_rvalid_o(int_rvalid_o), .mii_req_i(mii_req_i),
  .mii_rdata_o(mii_rdata_o), .mii_rvalid_o(mii_rvalid_o),
  .an_complete_o(an_complete_o));
`default_nettype wire

/* File: bench/vpsr_mgmt_station.sv */
// Management station model that reaches the registers by index.
`timescale 1ns/1ps
`default_nettype none
module vpsr_mgmt_station (
  // Clock.
  input wire logic core_clk_i,
  // Request towards the registers.
  output var vpsr_pkg::vpsr_mii_req_t mii_req_o,
  // Answer from the registers.
  input wire logic [15:0] mii_rdata_i,
  input wire logic mii_rvalid_i
);
  // The station starts idle.
  initial mii_req_o = '0;
  // One access, held over one edge; released lines show inverted values
  // so that a stale read cannot pass by luck.
  task automatic access(input logic wr, input logic [4:0] idx,
      input logic [15:0] wd, output logic [15:0] rd, output logic ok);
    @(negedge core_clk_i);
    mii_req_o = {wr, ~wr, idx, wd};
    @(negedge core_clk_i);
    rd = mii_rdata_i;
    ok = (mii_rvalid_i === ~wr);
    mii_req_o = {2'b00, ~idx, ~wd};
  endtask
endmodule
`default_nettype wire

/* File: bench/vpsr_regs_tb.sv */
// Self-checking bench for the emulated PHY status and identifier registers.
`timescale 1ns/1ps
`default_nettype none
module vpsr_regs_tb;
  // Short settle time keeps the run brief.
  localparam int unsigned SETTLE = 6;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic soft_rst = 1'b0;
  vpsr_pkg::vpsr_int_req_t int_req = '0;
  vpsr_pkg::vpsr_mii_req_t mii_req;
  logic [31:0] int_rdata;
  logic int_rvalid;
  logic [15:0] mii_rdata;
  logic mii_rvalid;
  logic an_done;
  int miscompares = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'he87ccea1;
  logic [31:0] v;
  logic [15:0] m;
  logic ok;
  always #50 core_clk_i = ~core_clk_i;
  vpsr_regs #(.AN_SETTLE_CYC(SETTLE), .AN_CNT_W(8)) u_vpsr_regs (
    .core_clk_i(core_clk_i), .rst_i(rst_i),
    .emulated_phy_soft_reset_i(soft_rst), .int_req_i(int_req),
    .int_rdata_o(int_rdata), .int_rvalid_o(int_rvalid),
    .mii_req_i(mii_req), .mii_rdata_o(mii_rdata),
    .mii_rvalid_o(mii_rvalid), .an_complete_o(an_done));
  vpsr_mgmt_station u_vpsr_mgmt_station (.core_clk_i(core_clk_i),
    .mii_req_o(mii_req), .mii_rdata_i(mii_rdata), .mii_rvalid_i(mii_rvalid));
  // Next random word.
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Expected status word for a given negotiation state.
  function automatic logic [15:0] exp_status(input logic an);
    return {1'b0, 4'hf, 3'b000, 1'b0, 1'b0, an, 5'b01101};
  endfunction
  // Counts one comparison and reports a mismatch.
  task automatic check(input string what, input logic [31:0] e,
      input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // One internal access, held over one edge, then released inverted.
  task automatic int_acc(input logic wr, input logic [8:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    @(negedge core_clk_i);
    int_req = {wr, ~wr, a, wd};
    @(negedge core_clk_i);
    rd = int_rdata;
    check("int_rvalid", {31'h0, ~wr}, {31'h0, int_rvalid});
    int_req = {2'b00, ~a, ~wd};
  endtask
  // Reads one register through both ports.
  task automatic rd_both(input logic [8:0] a, input logic [4:0] i,
      input logic [15:0] e);
    int_acc(1'b0, a, 32'h0, v);
    check("int_rdata", {16'h0000, e}, v);
    u_vpsr_mgmt_station.access(1'b0, i, 16'h0, m, ok);
    check("mii_rdata", {16'h0000, e}, {16'h0000, m});
    check("mii_rvalid", 32'h1, {31'h0, ok});
  endtask
  // Main sequence of tests.
  initial begin
    repeat (5) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    rd_both(9'h1c4, 5'h01, exp_status(1'b0));
    $display("test status_after_reset done");
    repeat (SETTLE + 4) @(negedge core_clk_i);
    rd_both(9'h1c4, 5'h01, exp_status(1'b1));
    check("an_complete", 32'h1, {31'h0, an_done});
    rd_both(9'h1c8, 5'h02, 16'h0000);
    rd_both(9'h1cc, 5'h03, 16'h0000);
    $display("test defaults done");
    for (int k = 0; k < 16; k++) begin
      seed = xorshift(seed);
      v = (k == 0) ? 32'hffffffff : seed;
      int_acc(1'b1, seed[0] ? 9'h1cc : 9'h1c8, v, v);
      rd_both(seed[0] ? 9'h1cc : 9'h1c8, seed[0] ? 5'h03 : 5'h02,
        (k == 0) ? 16'hffff : seed[15:0]);
      seed = xorshift(seed);
      u_vpsr_mgmt_station.access(1'b1, {4'h1, seed[0]}, seed[31:16], m, ok);
      check("mii_wr_quiet", 32'h1, {31'h0, ok});
      rd_both(seed[0] ? 9'h1cc : 9'h1c8, {4'h1, seed[0]},
        seed[31:16]);
    end
    $display("test ident_random done");
    int_acc(1'b1, 9'h1c4, 32'hffff0000, v);
    u_vpsr_mgmt_station.access(1'b1, 5'h01, 16'h87f2, m, ok);
    check("mii_wr_status_quiet", 32'h1, {31'h0, ok});
    rd_both(9'h1c4, 5'h01, exp_status(1'b1));
    rd_both(9'h1c0, 5'h00, 16'h0000);
    rd_both(9'h1d0, 5'h04, 16'h0000);
    $display("test read_only_and_unmapped done");
    int_acc(1'b1, 9'h1c8, 32'h00005a5a, v);
    @(negedge core_clk_i);
    soft_rst = 1'b1;
    @(negedge core_clk_i);
    soft_rst = 1'b0;
    rd_both(9'h1c4, 5'h01, exp_status(1'b0));
    rd_both(9'h1c8, 5'h02, 16'h0000);
    rd_both(9'h1cc, 5'h03, 16'h0000);
    repeat (SETTLE + 4) @(negedge core_clk_i);
    rd_both(9'h1c4, 5'h01, exp_status(1'b1));
    $display("test soft_reset done");
    final_report();
  end
  // Cuts a hang short.
  initial begin
    repeat (3000) @(posedge core_clk_i);
    miscompares++;
    final_report();
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
